// [hw/bus_hold_snoop_pkg.sv]
// Shared constants and types for the bus hold and snoop response block.
package bus_hold_snoop_pkg;

	// Address field positions.
	localparam int ADDR_HI = 31;
	localparam int QWORD_LO = 3;
	localparam int LINE_LO = 5;
	localparam int LINE_W = ADDR_HI - LINE_LO + 1;

	// Burst and transfer counts.
	localparam logic [1:0] BURST_LAST_BEAT = 2'h3;
	localparam logic [1:0] SINGLE_LAST_BEAT = 2'h0;

	// Consecutive clocks the address float request must precede a snoop strobe.
	localparam logic [1:0] AFLOAT_MIN_CLOCKS = 2'h2;

	// Tag store geometry: two first-level caches and one second-level cache.
	localparam int NUM_CACHES = 3;
	localparam int ENTRIES_PER_CACHE = 4;
	localparam int TOTAL_ENTRIES = NUM_CACHES * ENTRIES_PER_CACHE;

	// Reset values.
	localparam logic [1:0] BEAT_RESET = 2'h0;
	localparam logic [1:0] AFLOAT_CNT_RESET = 2'h0;

	typedef enum logic [1:0] {
		LINE_INVALID = 2'h0,
		LINE_SHARED = 2'h1,
		LINE_EXCLUSIVE = 2'h2,
		LINE_MODIFIED = 2'h3
	} line_state_t;

	// Gray coded along idle, start, data, released, writeback start, writeback data.
	typedef enum logic [2:0] {
		BUS_IDLE = 3'h0,
		BUS_START = 3'h1,
		BUS_DATA = 3'h3,
		BUS_RELEASED = 3'h2,
		BUS_WB_START = 3'h6,
		BUS_WB_DATA = 3'h7
	} bus_state_t;

endpackage

// [hw/snoop_tag_store.sv]
// Tag store for all three caches with snoop lookup and state update.
`timescale 1ns/1ps
module snoop_tag_store (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Line fill from the core
	input wire logic fill_valid_i,
	input wire logic [1:0] fill_cache_i,
	input wire logic [1:0] fill_index_i,
	input wire logic [bus_hold_snoop_pkg::LINE_W-1:0] fill_tag_i,
	input wire bus_hold_snoop_pkg::line_state_t fill_state_i,
	// Snoop probe
	input wire logic [bus_hold_snoop_pkg::LINE_W-1:0] probe_tag_i,
	input wire logic probe_commit_i,
	input wire logic probe_drop_i,
	// Lookup result
	output logic hit_o,
	output logic dirty_o
);
	localparam int N = bus_hold_snoop_pkg::TOTAL_ENTRIES;

	logic [bus_hold_snoop_pkg::LINE_W-1:0] tag_reg [N];
	logic [bus_hold_snoop_pkg::LINE_W-1:0] tag_next [N];
	bus_hold_snoop_pkg::line_state_t state_reg [N];
	bus_hold_snoop_pkg::line_state_t state_next [N];
	logic [N-1:0] match;
	logic [N-1:0] dirty_match;
	logic [3:0] fill_slot;

	// Four entries per cache, so the slot is the cache number above the index.
	assign fill_slot = {fill_cache_i, fill_index_i};

	////////////////////////////////////////////////////////////////////////////////
	// Each entry compares the snoop address and takes its next state.
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_entry
			assign match[g] = (state_reg[g] != bus_hold_snoop_pkg::LINE_INVALID)
				&& (tag_reg[g] == probe_tag_i);
			assign dirty_match[g] = match[g]
				&& (state_reg[g] == bus_hold_snoop_pkg::LINE_MODIFIED);

			always_comb begin
				tag_next[g] = tag_reg[g];
				state_next[g] = state_reg[g];
				if (probe_commit_i && match[g]) begin
					// A found line is dropped or demoted; a modified one also gets a writeback cycle on the bus.
					state_next[g] = probe_drop_i ? bus_hold_snoop_pkg::LINE_INVALID
						: bus_hold_snoop_pkg::LINE_SHARED;
				end else if (fill_valid_i && (fill_slot == 4'(g))) begin
					tag_next[g] = fill_tag_i;
					state_next[g] = fill_state_i;
				end
			end

			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					tag_reg[g] <= '0;
					state_reg[g] <= bus_hold_snoop_pkg::LINE_INVALID;
				end else begin
					tag_reg[g] <= tag_next[g];
					state_reg[g] <= state_next[g];
				end
			end
		end
	endgenerate

	assign hit_o = |match;
	assign dirty_o = |dirty_match;

endmodule

// [hw/bus_hold_and_snoop_response.sv]
// Bus release handshake, address float and snoop response for the processor bus.
//
// Overview of operation
// - Finish running cycle before acknowledging release.
// - Float address, data, strobes with acknowledge.
// - Acknowledge one edge after final ready.
// - Sample yield each edge; wait for locked sequences.
// - Drop acknowledge the edge after yield negates.
// - Cycle start may coincide with acknowledge drop.
// - Snoop valid if sampled before yield negation.
// - Drive match outputs on the edge that samples snoop.
// - Clean hit: match set, dirty clear.
// - Modified hit: both match outputs set.
// - Miss: both match outputs clear.
// - Match holds until next snoop; dirty implies match.
// - Dirty hit runs writeback with latched address.
// - Dirty stays until edge after last ready.
// - Drop input invalidates, else line becomes shared.
// - Compare snoop address with all three caches.
// - Address float floats only address and parity.
// - Address returns when float request negates.
// - Address parity fault pulses one clock.
// - Float-snoop writeback precedes any new cycle.
`timescale 1ns/1ps
module bus_hold_and_snoop_response (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Arbitration and snoop pins
	input wire logic bus_yield_request_i,
	input wire logic address_float_request_i,
	input wire logic external_snoop_strobe_n_i,
	input wire logic snoop_drop_line_i,
	input wire logic burst_ready_ack_n_i,
	output logic bus_release_ack_o,
	output logic snoop_match_n_o,
	output logic snoop_match_dirty_n_o,
	output logic address_parity_fault_n_o,
	// Address pins and parity
	input wire logic [bus_hold_snoop_pkg::ADDR_HI:bus_hold_snoop_pkg::QWORD_LO] addr_i,
	input wire logic address_parity_line_i,
	output logic [bus_hold_snoop_pkg::ADDR_HI:bus_hold_snoop_pkg::QWORD_LO] addr_o,
	output logic address_parity_line_o,
	output logic addr_oe_o,
	// Cycle start, direction and enable for data, byte enables and cycle definition
	output logic cycle_start_strobe_n_o,
	output logic cycle_write_o,
	output logic bus_oe_o,
	// Core cycle requests
	input wire logic core_req_i,
	input wire logic [bus_hold_snoop_pkg::ADDR_HI:bus_hold_snoop_pkg::QWORD_LO] core_addr_i,
	input wire logic core_write_i,
	input wire logic core_burst_i,
	input wire logic core_locked_i,
	output logic core_grant_o,
	output logic core_done_o,
	// Core line fills into the tag store
	input wire logic fill_valid_i,
	input wire logic [1:0] fill_cache_i,
	input wire logic [1:0] fill_index_i,
	input wire logic [bus_hold_snoop_pkg::LINE_W-1:0] fill_tag_i,
	input wire bus_hold_snoop_pkg::line_state_t fill_state_i
);
	localparam int AHI = bus_hold_snoop_pkg::ADDR_HI;
	localparam int QLO = bus_hold_snoop_pkg::QWORD_LO;
	localparam int LLO = bus_hold_snoop_pkg::LINE_LO;

	bus_hold_snoop_pkg::bus_state_t state_reg, state_next;
	logic [1:0] beat_reg, beat_next;
	logic [1:0] last_beat_reg, last_beat_next;
	logic [AHI:QLO] addr_reg, addr_next;
	logic write_reg, write_next;
	logic ack_reg, ack_next;
	logic ads_n_reg, ads_n_next;
	logic addr_oe_reg, addr_oe_next;
	logic bus_oe_reg, bus_oe_next;
	logic hit_n_reg, hit_n_next;
	logic snoop_match_dirty_n_reg, snoop_match_dirty_n_next;
	logic address_parity_fault_n_reg, address_parity_fault_n_next;
	logic wb_pending_reg, wb_pending_next;
	logic wb_done_reg, wb_done_next;
	logic [bus_hold_snoop_pkg::LINE_W-1:0] wb_line_reg, wb_line_next;
	logic [1:0] afloat_cnt_reg, afloat_cnt_next;
	logic yield_seen_reg, yield_seen_next;
	logic snoop_ok;
	logic parity_bad;
	logic lk_hit;
	logic lk_dirty;
	logic last_ready;

	////////////////////////////////////////////////////////////////////////////////
	// Snoop qualification and tag lookup.

	assign snoop_ok = !external_snoop_strobe_n_i && ((ack_reg && yield_seen_reg)
		|| (address_float_request_i
		&& afloat_cnt_reg >= bus_hold_snoop_pkg::AFLOAT_MIN_CLOCKS));
	assign parity_bad = ^{addr_i, address_parity_line_i};
	assign last_ready = !burst_ready_ack_n_i && (beat_reg == last_beat_reg);

	snoop_tag_store u_tags (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.fill_valid_i(fill_valid_i),
		.fill_cache_i(fill_cache_i),
		.fill_index_i(fill_index_i),
		.fill_tag_i(fill_tag_i),
		.fill_state_i(fill_state_i),
		.probe_tag_i(addr_i[AHI:LLO]),
		.probe_commit_i(snoop_ok),
		.probe_drop_i(snoop_drop_line_i),
		.hit_o(lk_hit),
		.dirty_o(lk_dirty)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Snoop result, writeback scheduling and float request counting.

	always_comb begin
		hit_n_next = hit_n_reg;
		snoop_match_dirty_n_next = snoop_match_dirty_n_reg;
		wb_pending_next = wb_pending_reg;
		wb_line_next = wb_line_reg;
		address_parity_fault_n_next = !(snoop_ok && parity_bad);
		afloat_cnt_next = AFLOAT_SAT(address_float_request_i, afloat_cnt_reg);
		yield_seen_next = bus_yield_request_i;
		if (wb_done_reg) begin
			snoop_match_dirty_n_next = 1'b1;
		end
		if (state_reg == bus_hold_snoop_pkg::BUS_WB_DATA && last_ready) begin
			wb_pending_next = 1'b0;
		end
		if (snoop_ok) begin
			hit_n_next = !lk_hit;
			snoop_match_dirty_n_next = !lk_dirty;
			if (lk_dirty) begin
				wb_pending_next = 1'b1;
				wb_line_next = addr_i[AHI:LLO];
			end
		end
	end

	function automatic logic [1:0] AFLOAT_SAT(input logic req, input logic [1:0] cnt);
		logic [1:0] res;
		res = 2'h0;
		if (req) begin
			res = (cnt == bus_hold_snoop_pkg::AFLOAT_MIN_CLOCKS) ? cnt : cnt + 2'h1;
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus cycle and release state machine.

	always_comb begin
		state_next = state_reg;
		beat_next = beat_reg;
		last_beat_next = last_beat_reg;
		addr_next = addr_reg;
		write_next = write_reg;
		wb_done_next = 1'b0;
		core_grant_o = 1'b0;
		core_done_o = 1'b0;
		case (state_reg)
			bus_hold_snoop_pkg::BUS_IDLE: begin
				if (wb_pending_next) begin
					state_next = bus_hold_snoop_pkg::BUS_WB_START;
				end else if (bus_yield_request_i && !core_locked_i) begin
					state_next = bus_hold_snoop_pkg::BUS_RELEASED;
				end else if (core_req_i && !address_float_request_i) begin
					state_next = bus_hold_snoop_pkg::BUS_START;
				end
			end
			bus_hold_snoop_pkg::BUS_RELEASED: begin
				if (!yield_seen_reg) begin
					if (wb_pending_next) begin
						state_next = bus_hold_snoop_pkg::BUS_WB_START;
					end else if (core_req_i && !address_float_request_i) begin
						state_next = bus_hold_snoop_pkg::BUS_START;
					end else begin
						state_next = bus_hold_snoop_pkg::BUS_IDLE;
					end
				end
			end
			bus_hold_snoop_pkg::BUS_START, bus_hold_snoop_pkg::BUS_WB_START: begin
				beat_next = bus_hold_snoop_pkg::BEAT_RESET;
				state_next = (state_reg == bus_hold_snoop_pkg::BUS_START)
					? bus_hold_snoop_pkg::BUS_DATA : bus_hold_snoop_pkg::BUS_WB_DATA;
			end
			bus_hold_snoop_pkg::BUS_DATA, bus_hold_snoop_pkg::BUS_WB_DATA: begin
				if (!burst_ready_ack_n_i) begin
					beat_next = beat_reg + 2'h1;
				end
				if (last_ready) begin
					// The cycle in flight always completes before any release.
					state_next = bus_hold_snoop_pkg::BUS_IDLE;
					core_done_o = (state_reg == bus_hold_snoop_pkg::BUS_DATA);
					wb_done_next = (state_reg == bus_hold_snoop_pkg::BUS_WB_DATA);
				end
			end
			default: begin
				state_next = bus_hold_snoop_pkg::BUS_IDLE;
			end
		endcase
		if (state_next == bus_hold_snoop_pkg::BUS_START
			&& state_reg != bus_hold_snoop_pkg::BUS_START) begin
			core_grant_o = 1'b1;
			addr_next = core_addr_i;
			write_next = core_write_i;
			last_beat_next = core_burst_i ? bus_hold_snoop_pkg::BURST_LAST_BEAT
				: bus_hold_snoop_pkg::SINGLE_LAST_BEAT;
		end
		if (state_next == bus_hold_snoop_pkg::BUS_WB_START
			&& state_reg != bus_hold_snoop_pkg::BUS_WB_START) begin
			addr_next = {wb_line_next, 2'h0};
			write_next = 1'b1;
			last_beat_next = bus_hold_snoop_pkg::BURST_LAST_BEAT;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drive: release acknowledge, strobes and output enables.

	always_comb begin
		ack_next = (state_next == bus_hold_snoop_pkg::BUS_RELEASED);
		ads_n_next = !(state_next == bus_hold_snoop_pkg::BUS_START
			|| state_next == bus_hold_snoop_pkg::BUS_WB_START);
		bus_oe_next = !ack_next;
		addr_oe_next = !ack_next && !address_float_request_i;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state_reg <= bus_hold_snoop_pkg::BUS_IDLE;
			beat_reg <= bus_hold_snoop_pkg::BEAT_RESET;
			last_beat_reg <= bus_hold_snoop_pkg::SINGLE_LAST_BEAT;
			addr_reg <= '0;
			write_reg <= 1'b0;
			ack_reg <= 1'b0;
			ads_n_reg <= 1'b1;
			addr_oe_reg <= 1'b1;
			bus_oe_reg <= 1'b1;
			hit_n_reg <= 1'b1;
			snoop_match_dirty_n_reg <= 1'b1;
			address_parity_fault_n_reg <= 1'b1;
			wb_pending_reg <= 1'b0;
			wb_done_reg <= 1'b0;
			wb_line_reg <= '0;
			afloat_cnt_reg <= bus_hold_snoop_pkg::AFLOAT_CNT_RESET;
			yield_seen_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			beat_reg <= beat_next;
			last_beat_reg <= last_beat_next;
			addr_reg <= addr_next;
			write_reg <= write_next;
			ack_reg <= ack_next;
			ads_n_reg <= ads_n_next;
			addr_oe_reg <= addr_oe_next;
			bus_oe_reg <= bus_oe_next;
			hit_n_reg <= hit_n_next;
			snoop_match_dirty_n_reg <= snoop_match_dirty_n_next;
			address_parity_fault_n_reg <= address_parity_fault_n_next;
			wb_pending_reg <= wb_pending_next;
			wb_done_reg <= wb_done_next;
			wb_line_reg <= wb_line_next;
			afloat_cnt_reg <= afloat_cnt_next;
			yield_seen_reg <= yield_seen_next;
		end
	end

	assign bus_release_ack_o = ack_reg;
	assign cycle_start_strobe_n_o = ads_n_reg;
	assign cycle_write_o = write_reg;
	assign bus_oe_o = bus_oe_reg;
	assign addr_oe_o = addr_oe_reg;
	assign addr_o = addr_reg;
	assign address_parity_line_o = ^addr_reg;
	assign snoop_match_n_o = hit_n_reg;
	assign snoop_match_dirty_n_o = snoop_match_dirty_n_reg;
	assign address_parity_fault_n_o = address_parity_fault_n_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the pin behaviour.

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	a_no_ack_midcycle: assert property (
		state_reg == bus_hold_snoop_pkg::BUS_DATA |-> !bus_release_ack_o)
		else $error("release acknowledged during a running cycle");
	a_float_with_ack: assert property (
		bus_release_ack_o |-> !bus_oe_o && !addr_oe_o)
		else $error("outputs driven while bus released");
	a_ack_after_ready: assert property (
		state_reg == bus_hold_snoop_pkg::BUS_DATA && last_ready && bus_yield_request_i
		&& !wb_pending_next ##1 bus_yield_request_i && !core_locked_i && !wb_pending_next
		|=> bus_release_ack_o && !$past(bus_release_ack_o))
		else $error("release acknowledge not one edge after final ready");
	a_locked_withheld: assert property (
		state_reg == bus_hold_snoop_pkg::BUS_IDLE && core_locked_i && !ack_reg
		|=> !bus_release_ack_o)
		else $error("release acknowledged inside a locked sequence");
	a_ack_drop: assert property (
		bus_release_ack_o && !bus_yield_request_i |-> ##2 !bus_release_ack_o)
		else $error("acknowledge held after yield negated");
	a_ack_stays: assert property (
		bus_release_ack_o && bus_yield_request_i && yield_seen_reg
		|=> bus_release_ack_o && !bus_oe_o)
		else $error("bus taken back while yield still asserted");
	a_clean_hit: assert property (
		snoop_ok && lk_hit && !lk_dirty |=> !snoop_match_n_o && snoop_match_dirty_n_o)
		else $error("clean hit result wrong");
	a_dirty_hit: assert property (
		snoop_ok && lk_dirty |=> !snoop_match_n_o && !snoop_match_dirty_n_o)
		else $error("dirty hit result wrong");
	a_snoop_miss: assert property (
		snoop_ok && !lk_hit |=> snoop_match_n_o && snoop_match_dirty_n_o)
		else $error("miss result wrong");
	a_dirty_implies: assert property (
		!snoop_match_dirty_n_o |-> !snoop_match_n_o)
		else $error("dirty match without match");
	a_wb_dirty_held: assert property (
		state_reg == bus_hold_snoop_pkg::BUS_WB_DATA |-> !snoop_match_dirty_n_o)
		else $error("dirty match dropped during writeback");
	a_wb_dirty_end: assert property (
		state_reg == bus_hold_snoop_pkg::BUS_WB_DATA && last_ready && !snoop_ok
		##1 !snoop_ok |=> snoop_match_dirty_n_o)
		else $error("dirty match not dropped after writeback");
	a_addr_float: assert property (
		address_float_request_i && !ack_next |=> !addr_oe_o && bus_oe_o)
		else $error("address float wrong");
	a_parity_pulse: assert property (
		!address_parity_fault_n_o |-> $past(snoop_ok) && $past(parity_bad))
		else $error("parity fault without cause");
	a_wb_first: assert property (
		wb_pending_reg |-> !core_grant_o)
		else $error("new cycle started before writeback");

	c_clean_hit: cover property (snoop_ok && lk_hit && !lk_dirty);
	c_dirty_wb: cover property (wb_done_reg);
	c_release: cover property (bus_release_ack_o ##1 !bus_release_ack_o);
	c_float_snoop: cover property (snoop_ok && !ack_reg);

endmodule

// [test/system_master_model.sv]
// Model of the system logic that answers device cycles and shares the address bus.
`timescale 1ns/1ps
module system_master_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Device cycle side
	input wire logic strobe_n_i,
	input wire logic bus_oe_i,
	input wire logic burst_i,
	input wire logic [1:0] wait_i,
	output logic ready_n_o,
	// Shared address bus
	input wire logic addr_oe_i,
	input wire logic [31:3] dev_addr_i,
	input wire logic dev_parity_i,
	input wire logic m_drive_i,
	input wire logic [31:3] m_addr_i,
	input wire logic m_bad_i,
	output logic [31:3] addr_bus_o,
	output logic parity_bus_o
);
	int left = 0;
	int gap = 0;
	logic tgl = 1'b0;
	initial ready_n_o = 1'b1;
	// Ready beats follow each cycle start, with a chosen number of wait states.
	always @(negedge clk_i) begin
		tgl = ~tgl;
		if (!nrst_i) begin
			left = 0;
			ready_n_o = 1'b1;
		end else if (left == 0 && strobe_n_i === 1'b0 && bus_oe_i === 1'b1) begin
			// The first ready is sampled no earlier than the edge after the strobe ends.
			left = burst_i ? 4 : 1;
			gap = wait_i;
			ready_n_o = 1'b1;
		end else if (left > 0 && gap == 0) begin
			ready_n_o = 1'b0;
			left--;
			gap = wait_i;
		end else begin
			ready_n_o = 1'b1;
			if (gap > 0) gap--;
		end
	end
	// A bus nobody drives shows a pattern that changes every cycle.
	assign addr_bus_o = addr_oe_i ? dev_addr_i : (m_drive_i ? m_addr_i : {29{tgl}});
	assign parity_bus_o = addr_oe_i ? dev_parity_i : (m_drive_i ? (^m_addr_i) ^ m_bad_i : tgl);
endmodule

// [test/tb_bus_hold_and_snoop_response.sv]
// Self-checking bench for the bus hold and snoop response block.
`timescale 1ns/1ps
module tb_bus_hold_and_snoop_response;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic yield = 1'b0;
	logic afloat = 1'b0;
	logic snoop_n = 1'b1;
	logic drop = 1'b0;
	logic core_req = 1'b0;
	logic [31:3] core_addr = 29'h0;
	logic core_write = 1'b0;
	logic core_burst = 1'b0;
	logic core_locked = 1'b0;
	logic fill_valid = 1'b0;
	logic [1:0] fill_cache = 2'h0;
	logic [1:0] fill_index = 2'h0;
	logic [26:0] fill_tag = 27'h0;
	bus_hold_snoop_pkg::line_state_t fill_state = bus_hold_snoop_pkg::LINE_INVALID;
	logic p_burst = 1'b0;
	logic [1:0] p_wait = 2'h0;
	logic m_drive = 1'b0;
	logic [31:3] m_addr = 29'h0;
	logic m_bad = 1'b0;
	logic ready_n, ack, hit_n, dirty_n, fault_n, ap_in, ap_out, addr_oe;
	logic strobe_n, cwr, bus_oe, grant, done;
	logic [31:3] addr_in, addr_out;
	logic [26:0] t [4];
	logic [26:0] st [6];
	logic [5:0] sd = 6'h01;
	logic [5:0] sh = 6'h1d;
	int err_total = 0;
	int check_count = 0;
	int i;
	always #12.5 clk_i = ~clk_i;
	bus_hold_and_snoop_response u_bus_hold_and_snoop_response (.clk_i(clk_i), .nrst_i(nrst_i),
		.bus_yield_request_i(yield), .address_float_request_i(afloat),
		.external_snoop_strobe_n_i(snoop_n), .snoop_drop_line_i(drop),
		.burst_ready_ack_n_i(ready_n), .bus_release_ack_o(ack), .snoop_match_n_o(hit_n),
		.snoop_match_dirty_n_o(dirty_n), .address_parity_fault_n_o(fault_n), .addr_i(addr_in),
		.address_parity_line_i(ap_in), .addr_o(addr_out), .address_parity_line_o(ap_out),
		.addr_oe_o(addr_oe), .cycle_start_strobe_n_o(strobe_n), .cycle_write_o(cwr),
		.bus_oe_o(bus_oe), .core_req_i(core_req), .core_addr_i(core_addr),
		.core_write_i(core_write), .core_burst_i(core_burst), .core_locked_i(core_locked),
		.core_grant_o(grant), .core_done_o(done), .fill_valid_i(fill_valid),
		.fill_cache_i(fill_cache), .fill_index_i(fill_index), .fill_tag_i(fill_tag),
		.fill_state_i(fill_state));
	system_master_model u_system_master_model (.clk_i(clk_i), .nrst_i(nrst_i),
		.strobe_n_i(strobe_n), .bus_oe_i(bus_oe), .burst_i(p_burst), .wait_i(p_wait),
		.ready_n_o(ready_n), .addr_oe_i(addr_oe), .dev_addr_i(addr_out), .dev_parity_i(ap_out),
		.m_drive_i(m_drive), .m_addr_i(m_addr), .m_bad_i(m_bad), .addr_bus_o(addr_in),
		.parity_bus_o(ap_in));
	////////////////////////////////////////////////////////////////////////////////
	task stop_test;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge clk_i);
		#1;
	endtask
	function logic sig(input int w);
		case (w)
			0: return grant;
			1: return done;
			2: return ack;
			default: return strobe_n;
		endcase
	endfunction
	task wait_on(input int w, input logic v);
		int n;
		for (n = 0; n < 200; n++) begin
			#1;
			if (sig(w) === v) break;
			@(negedge clk_i);
		end
		if (n == 200) begin
			chk("wait", 32'h1, 32'h0);
			stop_test();
		end
	endtask
	task fill(input logic [1:0] c, input logic [1:0] x, input logic [26:0] tg,
		input bus_hold_snoop_pkg::line_state_t s);
		fill_valid = 1'b1;
		fill_cache = c;
		fill_index = x;
		fill_tag = tg;
		fill_state = s;
		tick(1);
		fill_valid = 1'b0;
	endtask
	task snoop(input logic [26:0] tg, input logic d, input logic bad);
		snoop_n = 1'b0;
		drop = d;
		m_drive = 1'b1;
		m_addr = {tg, 2'h0};
		m_bad = bad;
		tick(1);
		snoop_n = 1'b1;
		m_drive = 1'b0;
		m_bad = 1'b0;
	endtask
	task chk_hit(input logic h, input logic d);
		tick(1);
		chk("hit", !h, hit_n);
		chk("dirty", !d, dirty_n);
	endtask
	task start_cycle(input logic wr, input logic bu);
		core_req = 1'b1;
		core_write = wr;
		core_burst = bu;
		core_addr = 29'($urandom());
		p_burst = bu;
		p_wait = 2'($urandom_range(2));
		wait_on(0, 1'b1);
		tick(1);
		core_req = 1'b0;
		chk("strobe", 1'b0, strobe_n);
		chk("write", wr, cwr);
	endtask
	task wb_beats;
		int b;
		int n;
		b = 0;
		for (n = 0; n < 60 && b < 4; n++) begin
			if (ready_n === 1'b0) b++;
			chk("dirty", 1'b0, dirty_n);
			tick(1);
		end
		chk("dirty", 1'b0, dirty_n);
		tick(1);
		chk("dirty", 1'b1, dirty_n);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(21));
		for (i = 0; i < 4; i++) begin
			t[i] = {25'($urandom()), 2'(i)};
		end
		st = '{t[0], t[0], t[1], t[1], t[3], 27'($urandom())};
		tick(12);
		nrst_i = 1'b1;
		chk("ack", 1'b0, ack);
		chk("hit", 1'b1, hit_n);
		chk("bus_oe", 1'b1, bus_oe);
		fill(2'h0, 2'h0, t[0], bus_hold_snoop_pkg::LINE_SHARED);
		fill(2'h1, 2'h2, t[1], bus_hold_snoop_pkg::LINE_EXCLUSIVE);
		fill(2'h2, 2'h0, t[2], bus_hold_snoop_pkg::LINE_MODIFIED);
		fill(2'h2, 2'h3, t[3], bus_hold_snoop_pkg::LINE_EXCLUSIVE);
		for (i = 0; i < 4; i++) begin
			start_cycle(1'($urandom()), 1'($urandom()));
			wait_on(1, 1'b1);
			tick(1);
		end
		start_cycle(1'b0, 1'b1);
		yield = 1'b1;
		tick(1);
		chk("ack", 1'b0, ack);
		wait_on(1, 1'b1);
		tick(1);
		chk("ack", 1'b0, ack);
		tick(1);
		chk("ack", 1'b1, ack);
		chk("bus_oe", 1'b0, bus_oe);
		chk("addr_oe", 1'b0, addr_oe);
		for (i = 0; i < 6; i++) begin
			snoop(st[i], sd[i], 1'b0);
			chk_hit(sh[i], 1'b0);
			chk("fault", 1'b1, fault_n);
			tick(1 + $urandom_range(3));
			chk("ack", 1'b1, ack);
			chk("hit", !sh[i], hit_n);
		end
		p_burst = 1'b1;
		yield = 1'b0;
		snoop(t[2], 1'b1, 1'b0);
		chk_hit(1'b1, 1'b1);
		chk("ack", 1'b0, ack);
		wait_on(3, 1'b0);
		chk("wb_addr", {t[2], 2'h0}, addr_out);
		chk("wb_write", 1'b1, cwr);
		wb_beats();
		start_cycle(1'b1, 1'b0);
		afloat = 1'b1;
		tick(1);
		chk("addr_oe", 1'b0, addr_oe);
		chk("bus_oe", 1'b1, bus_oe);
		wait_on(1, 1'b1);
		afloat = 1'b0;
		tick(1);
		chk("addr_oe", 1'b1, addr_oe);
		afloat = 1'b1;
		tick(1);
		snoop(st[5], 1'b0, 1'b0);
		chk_hit(1'b1, 1'b0);
		snoop(st[5], 1'b0, 1'b1);
		chk("fault", 1'b0, fault_n);
		chk_hit(1'b0, 1'b0);
		chk("fault", 1'b1, fault_n);
		fill(2'h2, 2'h1, t[2], bus_hold_snoop_pkg::LINE_MODIFIED);
		p_burst = 1'b1;
		snoop(t[2], 1'b0, 1'b0);
		chk("wb_strobe", 1'b0, strobe_n);
		chk_hit(1'b1, 1'b1);
		core_req = 1'b1;
		core_write = 1'b0;
		core_burst = 1'b1;
		chk("wb_write", 1'b1, cwr);
		chk("wb_addr", {t[2], 2'h0}, addr_out);
		afloat = 1'b0;
		wait_on(0, 1'b1);
		tick(1);
		core_req = 1'b0;
		wait_on(1, 1'b1);
		tick(1);
		core_locked = 1'b1;
		start_cycle(1'b1, 1'b0);
		yield = 1'b1;
		wait_on(1, 1'b1);
		tick(3);
		chk("ack", 1'b0, ack);
		core_locked = 1'b0;
		wait_on(2, 1'b1);
		yield = 1'b0;
		tick(1);
		chk("ack", 1'b1, ack);
		tick(1);
		chk("ack", 1'b0, ack);
		stop_test();
	end
endmodule
